// file: logic/smc_params.svh
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

// Register offsets on the plain register port.
`define SMC_ADDR_STANDBY 4'h0
`define SMC_ADDR_ACCEPT 4'h1
`define SMC_ADDR_STATUS 4'h2
`define SMC_ADDR_CONFIG 4'h3
// Standby control field positions.
`define SMC_BIT_HALT 0
`define SMC_BIT_STOP 1
// Config field positions.
`define SMC_BIT_XTAL 0
`define SMC_BIT_CPU_HS 1
`define SMC_BIT_HS_ON 2
// Unlock acceptor codes (upper nibble).
`define SMC_UNLOCK_FIRST 4'h5
`define SMC_UNLOCK_SECOND 4'hA
// Start vectors.
`define SMC_VEC_NORMAL 16'h0002
`define SMC_VEC_BREAK 16'h0004
// Interrupt levels.
`define SMC_LVL_NONE 2'h0
`define SMC_LVL_MASK 2'h1
`define SMC_LVL_NMI 2'h2
`define SMC_LVL_EMU 2'h3
// Stabilisation pulse counts, STOP entry delay and resume slot count.
`define SMC_CNT_XTAL 14'h2000
`define SMC_CNT_HS 14'h1000
`define SMC_CNT_RC_LS 14'h0010
`define SMC_CNT_RC_HS 14'h0080
`define SMC_ENTRY_DELAY 2'h2
`define SMC_RESUME_SLOTS 2'h2
`endif

// file: logic/smc_pkg.sv
package smc_pkg;
  typedef enum logic [2:0] {
    SMC_RUN = 3'b000,
    SMC_HALT = 3'b001,
    SMC_STOP_PEND = 3'b010,
    SMC_STOP = 3'b011,
    SMC_WAKE = 3'b100
  } smc_state_t;

  typedef enum logic [1:0] {
    SMC_RST_POWER = 2'b00,
    SMC_RST_BREAK = 2'b01
  } smc_rst_cause_t;

  typedef struct packed {
    logic [1:0] level;
    logic master_en;
    logic nmi_req;
    logic wdt_req;
    logic mask_en;
    logic mask_req;
    logic pin_en;
    logic pin_req;
  } smc_irq_t;

  typedef struct packed {
    logic ls_osc_en;
    logic hs_osc_en;
    logic ls_clk_en;
    logic hs_clk_en;
    logic ls_on_xtal;
  } smc_clk_t;
endpackage : smc_pkg

// file: logic/smc_ctrl.sv
`include "smc_params.svh"
module smc_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Reset release event and its cause
  input wire logic rst_done,
  input wire smc_pkg::smc_rst_cause_t rst_cause,
  input wire logic [1:0] break_level,
  output logic [15:0] start_vector,
  // Interrupt side, synchronous to clk_sys
  input wire smc_pkg::smc_irq_t irq_in,
  // Oscillator stabilisation pulses from pins
  input wire logic ls_pulse_pin,
  input wire logic hs_pulse_pin,
  input wire logic ls_start_done,
  input wire logic hs_start_done,
  // Outputs to core and clock tree
  output logic cpu_stop,
  output logic periph_stop,
  output logic take_vector,
  output logic [1:0] resume_slots,
  output logic clock_backup_interrupt,
  output smc_pkg::smc_clk_t clk_ctl
);
  import smc_pkg::*;

  // ************************************************
  // Pin synchronisers
  // ************************************************
  logic [2:0] ls_sync_reg;
  logic [2:0] hs_sync_reg;
  logic ls_level_reg;
  logic hs_level_reg;
  logic ls_rise;
  logic hs_rise;
  // Only the agreement of stages two and three reaches the pulse counters, so a
  // glitch shorter than two clocks is never counted as an oscillator pulse.

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ls_sync_reg <= 3'h0;
      hs_sync_reg <= 3'h0;
      ls_level_reg <= 1'b0;
      hs_level_reg <= 1'b0;
    end else begin
      ls_sync_reg <= {ls_sync_reg[1:0], ls_pulse_pin};
      hs_sync_reg <= {hs_sync_reg[1:0], hs_pulse_pin};
      // A change counts only once stages two and three agree.
      if (ls_sync_reg[1] == ls_sync_reg[2]) begin
        ls_level_reg <= ls_sync_reg[2];
      end
      if (hs_sync_reg[1] == hs_sync_reg[2]) begin
        hs_level_reg <= hs_sync_reg[2];
      end
    end
  end

  logic ls_prev_reg;
  logic hs_prev_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ls_prev_reg <= 1'b0;
      hs_prev_reg <= 1'b0;
    end else begin
      ls_prev_reg <= ls_level_reg;
      hs_prev_reg <= hs_level_reg;
    end
  end
  assign ls_rise = ls_level_reg & ~ls_prev_reg;
  assign hs_rise = hs_level_reg & ~hs_prev_reg;

  // ************************************************
  // Start vector selection
  // ************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      start_vector <= `SMC_VEC_NORMAL;
    end else if (rst_done) begin
      // The vector is latched once per reset release and held until the next one.
      if (rst_cause == SMC_RST_BREAK && break_level < `SMC_LVL_NMI) begin
        start_vector <= `SMC_VEC_BREAK;
      end else begin
        start_vector <= `SMC_VEC_NORMAL;
      end
    end
  end

  // ************************************************
  // Wake qualification
  // ************************************************
  logic nmi_wake;
  logic mask_wake;
  logic pin_wake;
  logic halt_wake;
  logic vector_ok;
  assign nmi_wake = irq_in.nmi_req | irq_in.wdt_req;
  assign mask_wake = irq_in.mask_en & irq_in.mask_req;
  assign pin_wake = irq_in.pin_en & irq_in.pin_req;
  assign halt_wake = nmi_wake | mask_wake | pin_wake;
  // Level 3 is reserved for the emulator and never vectors.
  // An external pin source is maskable, so it vectors under the same gate as
  // every other maskable source.
  always_comb begin
    vector_ok = 1'b0;
    if (nmi_wake && irq_in.level != `SMC_LVL_EMU) begin
      vector_ok = 1'b1;
    end else if ((mask_wake || pin_wake) && irq_in.master_en && irq_in.level <= `SMC_LVL_MASK) begin
      vector_ok = 1'b1;
    end
  end

  // ************************************************
  // Register writes and unlock acceptor
  // ************************************************
  logic wr_standby;
  logic wr_accept;
  logic wr_config;
  assign wr_standby = reg_wr && reg_addr == `SMC_ADDR_STANDBY;
  assign wr_accept = reg_wr && reg_addr == `SMC_ADDR_ACCEPT;
  assign wr_config = reg_wr && reg_addr == `SMC_ADDR_CONFIG;

  smc_state_t state_reg;
  smc_state_t state_next;
  logic first_seen_reg;
  logic unlock_reg;
  logic halt_bit_reg;
  logic stop_bit_reg;
  logic [2:0] config_reg;
  logic [1:0] entry_cnt_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      first_seen_reg <= 1'b0;
      unlock_reg <= 1'b0;
    end else if (state_reg == SMC_STOP_PEND) begin
      first_seen_reg <= 1'b0;
      unlock_reg <= 1'b0;
    end else if (wr_accept) begin
      // Any other value breaks the sequence so a stray write cannot arm STOP.
      first_seen_reg <= reg_wdata[7:4] == `SMC_UNLOCK_FIRST;
      if (first_seen_reg && reg_wdata[7:4] == `SMC_UNLOCK_SECOND) begin
        unlock_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      config_reg <= 3'h0;
    end else if (wr_config) begin
      config_reg <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      halt_bit_reg <= 1'b0;
    end else if (state_reg == SMC_HALT && halt_wake) begin
      // A halted core cannot issue a new halt write, so the clear may take priority.
      halt_bit_reg <= 1'b0;
    end else if (wr_standby && reg_wdata[`SMC_BIT_HALT]) begin
      halt_bit_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stop_bit_reg <= 1'b0;
    end else if (state_reg == SMC_STOP && pin_wake) begin
      stop_bit_reg <= 1'b0;
    end else if (wr_standby && reg_wdata[`SMC_BIT_STOP] && unlock_reg) begin
      stop_bit_reg <= 1'b1;
    end
  end

  // ************************************************
  // Mode state machine
  // ************************************************
  logic [13:0] ls_cnt_reg;
  logic [13:0] hs_cnt_reg;
  logic [13:0] rc_cnt_reg;
  logic hs_was_on_reg;
  logic ls_ready;
  logic hs_ready;
  logic wake_done;

  assign hs_ready = !hs_was_on_reg || (hs_start_done && hs_cnt_reg >= `SMC_CNT_HS);
  assign ls_ready = config_reg[`SMC_BIT_CPU_HS] ? rc_cnt_reg >= `SMC_CNT_RC_HS
                  : (config_reg[`SMC_BIT_XTAL] ? (ls_start_done && ls_cnt_reg >= `SMC_CNT_XTAL)
                  : rc_cnt_reg >= `SMC_CNT_RC_LS);
  // High-speed CPU leaves STOP on the high-speed count alone.
  assign wake_done = config_reg[`SMC_BIT_CPU_HS] ? hs_ready : (ls_ready && hs_ready);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SMC_RUN: begin
        // HALT wins when both request bits are set in one cycle.
        if (halt_bit_reg) begin
          state_next = SMC_HALT;
        end else if (stop_bit_reg) begin
          state_next = SMC_STOP_PEND;
        end
      end
      SMC_HALT: begin
        if (halt_wake) begin
          state_next = SMC_RUN;
        end
      end
      SMC_STOP_PEND: begin
        if (entry_cnt_reg == `SMC_ENTRY_DELAY) begin
          state_next = SMC_STOP;
        end
      end
      SMC_STOP: begin
        if (pin_wake) begin
          state_next = SMC_WAKE;
        end
      end
      SMC_WAKE: begin
        if (wake_done) begin
          state_next = SMC_RUN;
        end
      end
      default: begin
        state_next = SMC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SMC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      entry_cnt_reg <= 2'h0;
    end else if (state_reg == SMC_STOP_PEND) begin
      entry_cnt_reg <= entry_cnt_reg + 2'h1;
    end else begin
      entry_cnt_reg <= 2'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hs_was_on_reg <= 1'b0;
    end else if (state_reg == SMC_STOP_PEND) begin
      hs_was_on_reg <= config_reg[`SMC_BIT_HS_ON] | config_reg[`SMC_BIT_CPU_HS];
    end
  end

  // ************************************************
  // Stabilisation counters
  // ************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ls_cnt_reg <= 14'h0;
      hs_cnt_reg <= 14'h0;
      rc_cnt_reg <= 14'h0;
    end else if (state_reg != SMC_WAKE && state_reg != SMC_RUN) begin
      // Every standby state restarts the counts so each wake sees fresh pulses.
      ls_cnt_reg <= 14'h0;
      hs_cnt_reg <= 14'h0;
      rc_cnt_reg <= 14'h0;
    end else begin
      // Each count saturates at its highest target, so a long run mode cannot wrap it.
      if (ls_rise && ls_start_done && ls_cnt_reg < `SMC_CNT_XTAL) begin
        ls_cnt_reg <= ls_cnt_reg + 14'h1;
      end
      if (hs_rise && hs_start_done && hs_cnt_reg < `SMC_CNT_HS) begin
        hs_cnt_reg <= hs_cnt_reg + 14'h1;
      end
      if (ls_rise && rc_cnt_reg < `SMC_CNT_RC_HS) begin
        rc_cnt_reg <= rc_cnt_reg + 14'h1;
      end
    end
  end

  // ************************************************
  // Clock control and events
  // ************************************************
  logic in_stop;
  logic xtal_ok;
  logic switch_xtal;
  assign in_stop = state_reg == SMC_STOP;
  assign xtal_ok = config_reg[`SMC_BIT_XTAL] && ls_start_done && ls_cnt_reg >= `SMC_CNT_XTAL;
  assign switch_xtal = xtal_ok && !clk_ctl.ls_on_xtal;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clk_ctl <= '{ls_osc_en: 1'b1, hs_osc_en: 1'b0, ls_clk_en: 1'b1, hs_clk_en: 1'b0, ls_on_xtal: 1'b0};
      clock_backup_interrupt <= 1'b0;
    end else begin
      clock_backup_interrupt <= 1'b0;
      // The clocks drop one cycle after the core is held, which is harmless
      // because the core no longer fetches by then.
      if (in_stop) begin
        clk_ctl <= '{ls_osc_en: 1'b0, hs_osc_en: 1'b0, ls_clk_en: 1'b0, hs_clk_en: 1'b0, ls_on_xtal: 1'b0};
      end else if (state_reg == SMC_WAKE) begin
        clk_ctl.ls_osc_en <= 1'b1;
        clk_ctl.hs_osc_en <= hs_was_on_reg;
        clk_ctl.hs_clk_en <= hs_was_on_reg && hs_ready;
        clk_ctl.ls_clk_en <= ls_ready;
      end else begin
        clk_ctl.hs_osc_en <= config_reg[`SMC_BIT_HS_ON] | config_reg[`SMC_BIT_CPU_HS];
        clk_ctl.hs_clk_en <= config_reg[`SMC_BIT_HS_ON] | config_reg[`SMC_BIT_CPU_HS];
        clk_ctl.ls_osc_en <= 1'b1;
        clk_ctl.ls_clk_en <= clk_ctl.ls_clk_en | ls_ready;
      end
      if (!in_stop && switch_xtal) begin
        clk_ctl.ls_on_xtal <= 1'b1;
        clock_backup_interrupt <= 1'b1;
      end
    end
  end

  // ************************************************
  // Core handshake outputs
  // ************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpu_stop <= 1'b0;
      periph_stop <= 1'b0;
      take_vector <= 1'b0;
      resume_slots <= 2'h0;
    end else begin
      // Decoding state_next keeps these outputs aligned with the state register.
      cpu_stop <= state_next != SMC_RUN && state_next != SMC_STOP_PEND;
      periph_stop <= state_next == SMC_STOP || state_next == SMC_WAKE;
      take_vector <= 1'b0;
      if ((state_reg == SMC_HALT || state_reg == SMC_WAKE) && state_next == SMC_RUN) begin
        take_vector <= vector_ok;
        resume_slots <= `SMC_RESUME_SLOTS;
      end
    end
  end

  // ************************************************
  // Register read port
  // ************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `SMC_ADDR_STANDBY) begin
        reg_rdata <= {6'h00, stop_bit_reg, halt_bit_reg};
      end else if (reg_addr == `SMC_ADDR_ACCEPT) begin
        reg_rdata <= {7'h00, unlock_reg};
      end else if (reg_addr == `SMC_ADDR_STATUS) begin
        reg_rdata <= {2'h0, clk_ctl.ls_on_xtal, hs_was_on_reg, 1'b0, state_reg};
      end else if (reg_addr == `SMC_ADDR_CONFIG) begin
        reg_rdata <= {5'h00, config_reg};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : smc_ctrl

// file: tb/smc_ctrl_sva.sv
`include "smc_params.svh"
module smc_ctrl_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register writes
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // Reset release
  input wire logic rst_done,
  input wire smc_pkg::smc_rst_cause_t rst_cause,
  input wire logic [1:0] break_level,
  input wire logic [15:0] start_vector,
  // Wake and clocks
  input wire smc_pkg::smc_irq_t irq_in,
  input wire logic cpu_stop,
  input wire logic periph_stop,
  input wire logic take_vector,
  input wire logic [1:0] resume_slots,
  input wire logic clock_backup_interrupt,
  input wire smc_pkg::smc_clk_t clk_ctl
);
  timeunit 1ns;
  timeprecision 1ns;
  import smc_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  a_vec_normal: assert property (rst_done && rst_cause == SMC_RST_POWER |=>
    start_vector == `SMC_VEC_NORMAL) else $error("normal start vector wrong");
  a_vec_break: assert property (rst_done && rst_cause == SMC_RST_BREAK |=>
    start_vector == (break_level >= 2'h2 ? `SMC_VEC_NORMAL : `SMC_VEC_BREAK)) else $error("break vector wrong");
  a_halt_entry: assert property (reg_wr && reg_addr == `SMC_ADDR_STANDBY && reg_wdata[0] && !cpu_stop
    |-> ##[1:3] cpu_stop) else $error("halt not entered");
  a_halt_wake: assert property (cpu_stop && !periph_stop && (irq_in.nmi_req || irq_in.wdt_req)
    |-> ##[1:2] !cpu_stop) else $error("halt not released");
  a_halt_hold: assert property (cpu_stop && !periph_stop && !irq_in.nmi_req && !irq_in.wdt_req
    && !(irq_in.mask_en && irq_in.mask_req) && !(irq_in.pin_en && irq_in.pin_req) |=> cpu_stop)
    else $error("halt left without request");
  a_vector_gate: assert property (take_vector |-> ($past(irq_in.nmi_req || irq_in.wdt_req) ?
    $past(irq_in.level) != 2'h3 : ($past(irq_in.master_en) && $past(irq_in.level) <= 2'h1)))
    else $error("vector taken when not allowed");
  a_resume_slots: assert property (take_vector |-> resume_slots == `SMC_RESUME_SLOTS)
    else $error("resume slots wrong");
  a_backup_xtal: assert property (clock_backup_interrupt |-> ##[0:1] clk_ctl.ls_on_xtal)
    else $error("backup without crystal switch");
  a_stop_clocks: assert property ($rose(periph_stop) |=> clk_ctl[4:1] == 4'h0)
    else $error("clocks still on in stop");
  cover property (take_vector);
  cover property ($rose(periph_stop));
  cover property (clock_backup_interrupt);
endmodule : smc_ctrl_sva

bind smc_ctrl smc_ctrl_sva u_smc_ctrl_sva (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .rst_done,
  .rst_cause, .break_level, .start_vector, .irq_in, .cpu_stop, .periph_stop, .take_vector, .resume_slots,
  .clock_backup_interrupt, .clk_ctl);

// file: tb/smc_osc_model.sv
module smc_osc_model #(
  parameter int HALF = 3,
  parameter int START = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Oscillator enables
  input wire smc_pkg::smc_clk_t clk_ctl,
  // Oscillator pins
  output logic ls_pulse_pin,
  output logic hs_pulse_pin,
  output logic ls_start_done,
  output logic hs_start_done
);
  timeunit 1ns;
  timeprecision 1ns;
  import smc_pkg::*;
  int ls_age;
  int hs_age;
  // A stopped oscillator drops its pin low and must sit out its start time again.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn || !clk_ctl.ls_osc_en) begin
      ls_age <= 0;
    end else begin
      ls_age <= ls_age + 1;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn || !clk_ctl.hs_osc_en) begin
      hs_age <= 0;
    end else begin
      hs_age <= hs_age + 1;
    end
  end
  assign ls_pulse_pin = ((ls_age / HALF) % 2) == 1;
  assign hs_pulse_pin = ((hs_age / HALF) % 2) == 1;
  assign ls_start_done = ls_age >= START;
  assign hs_start_done = hs_age >= START;
endmodule : smc_osc_model

// file: tb/smc_ctrl_tb.sv
`include "smc_params.svh"
module smc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import smc_pkg::*;
  logic clk_sys, rstn, reg_wr, reg_rd, rst_done, ls_pulse_pin, hs_pulse_pin, ls_start_done, hs_start_done;
  logic cpu_stop, periph_stop, take_vector, clock_backup_interrupt, tv, bk, ls_q, hs_q;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [1:0] break_level, resume_slots;
  logic [15:0] start_vector;
  smc_rst_cause_t rst_cause;
  smc_irq_t irq_in;
  smc_clk_t clk_ctl;
  int n_fail, total_checks, n_ls, n_hs;
  logic [8:0] halt_irq [7] = '{9'h04C, 9'h14C, 9'h00C, 9'h1A0, 9'h120, 9'h010, 9'h0C3};
  logic [6:0] exp_tv = 7'h71;
  smc_ctrl u_smc_ctrl (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rst_done,
    .rst_cause, .break_level, .start_vector, .irq_in, .ls_pulse_pin, .hs_pulse_pin, .ls_start_done,
    .hs_start_done, .cpu_stop, .periph_stop, .take_vector, .resume_slots, .clock_backup_interrupt, .clk_ctl);
  smc_osc_model u_smc_osc_model (.clk_sys, .rstn, .clk_ctl, .ls_pulse_pin, .hs_pulse_pin, .ls_start_done,
    .hs_start_done);
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    ls_q <= ls_pulse_pin;
    hs_q <= hs_pulse_pin;
    if (ls_pulse_pin && !ls_q) n_ls <= n_ls + 1;
    if (hs_pulse_pin && !hs_q) n_hs <= n_hs + 1;
  end
  // ****
  // Bus and check tasks
  // ****
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : rd
  // Waits for cpu_stop (sel 0) or periph_stop to reach val, noting any event pulses meanwhile.
  task wait_for(input int sel, input logic val, input int bound);
    int i;
    tv = 1'h0;
    bk = 1'h0;
    for (i = 0; i < bound; i++) begin
      @(posedge clk_sys);
      #1 tv |= take_vector;
      bk |= clock_backup_interrupt;
      if ((sel == 0 ? cpu_stop : periph_stop) === val) break;
    end
    repeat (2) begin
      @(posedge clk_sys);
      #1 tv |= take_vector;
      bk |= clock_backup_interrupt;
    end
    if (i == bound) begin
      n_fail++;
      $display("MISMATCH t=%0t wait ran out", $time);
      final_report();
    end
  endtask : wait_for
  task stop_wake(input logic [7:0] cfg, input int bound);
    wr(`SMC_ADDR_CONFIG, cfg);
    wr(`SMC_ADDR_ACCEPT, 8'h5C);
    wr(`SMC_ADDR_ACCEPT, 8'hA3);
    rd(`SMC_ADDR_ACCEPT);
    chk(d[0], 1'h1);
    wr(`SMC_ADDR_STANDBY, 8'h02);
    wait_for(1, 1'h1, 8);
    chk(clk_ctl[4:1], 4'h0);
    rd(`SMC_ADDR_ACCEPT);
    chk(d[0], 1'h0);
    rd(`SMC_ADDR_STATUS);
    chk(d[2:0], 3'h3);
    chk(d[4], cfg[2] | cfg[1]);
    @(posedge clk_sys);
    irq_in <= 9'h003;
    n_ls <= 0;
    n_hs <= 0;
    wait_for(0, 1'h0, bound);
    @(posedge clk_sys);
    irq_in <= '0;
  endtask : stop_wake
  // ****
  // Main sequence
  // ****
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, rst_done, break_level} = '0;
    rst_cause = SMC_RST_POWER;
    irq_in = '0;
    {n_fail, total_checks, n_ls, n_hs} = '0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'h1;
    #1 chk(start_vector, `SMC_VEC_NORMAL);
    chk(clk_ctl, 5'h14);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      rst_done <= 1'h1;
      rst_cause <= smc_rst_cause_t'({1'h0, i[1]});
      break_level <= {i[0], 1'h0};
      @(posedge clk_sys);
      rst_done <= 1'h0;
      #1 chk(start_vector, (i[1] && !i[0]) ? `SMC_VEC_BREAK : `SMC_VEC_NORMAL);
    end
    for (int i = 0; i < 7; i++) begin
      wr(`SMC_ADDR_STANDBY, 8'h01);
      wait_for(0, 1'h1, 8);
      if (i == 0) begin
        @(posedge clk_sys);
        irq_in <= 9'h044;
        repeat (10) @(posedge clk_sys);
        #1 chk(cpu_stop, 1'h1);
      end
      @(posedge clk_sys);
      irq_in <= halt_irq[i];
      wait_for(0, 1'h0, 8);
      chk(tv, exp_tv[i]);
      chk(resume_slots, 2'h2);
      @(posedge clk_sys);
      irq_in <= '0;
      rd(`SMC_ADDR_STANDBY);
      chk(d[0], 1'h0);
    end
    wr(`SMC_ADDR_STANDBY, 8'h02);
    rd(`SMC_ADDR_STANDBY);
    chk(d[1], 1'h0);
    wr(`SMC_ADDR_ACCEPT, 8'h57);
    wr(`SMC_ADDR_CONFIG, 8'h00);
    rd(`SMC_ADDR_ACCEPT);
    chk(d[0], 1'h0);
    stop_wake(8'h00, 2000);
    chk(n_ls >= 16, 1'h1);
    chk(clk_ctl[3:2], 2'h1);
    stop_wake(8'h06, 30000);
    chk(n_hs >= 4096, 1'h1);
    chk(clk_ctl[3:1], 3'h7);
    stop_wake(8'h01, 60000);
    for (int k = 0; k < 20 && !bk; k++) begin
      @(posedge clk_sys);
      #1 bk |= clock_backup_interrupt;
    end
    chk(bk, 1'h1);
    chk(n_ls >= 8192, 1'h1);
    chk(clk_ctl.ls_on_xtal, 1'h1);
    rd(`SMC_ADDR_STATUS);
    chk(d[5], 1'h1);
    final_report();
  end
endmodule : smc_ctrl_tb
